// File: rtl/psc_cmd_core.sv
// top of the command interpreter: run state, alarm handling and answers
module psc_cmd_core (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        remote_sel,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_code,
  input  wire logic        cmd_port,
  input  wire logic        btn_start,
  input  wire logic        btn_stop,
  input  wire logic        btn_reset,
  input  wire logic        fault_present,
  input  wire logic [15:0] fault_code,
  input  wire logic        speed_reached,
  input  wire logic        speed_zero,
  output logic             ans_valid,
  output logic [15:0]      ans_code,
  output logic [15:0]      ans_sub,
  output logic             ans_port,
  output logic             accel_cmd,
  output logic             decel_cmd,
  output logic             buzzer_on,
  output logic             alarm_latched,
  output logic [1:0]       mode_out
);

  // -----------------------------------------------------------------------------
  // operation mode
  // -----------------------------------------------------------------------------
  psc_pkg::psc_mode_t mode;

  psc_mode_fsm u_mode (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .remote_sel (remote_sel),
    .cmd_valid  (cmd_valid),
    .cmd_code   (cmd_code),
    .cmd_port   (cmd_port),
    .mode       (mode)
  );

  function automatic logic [15:0] mode_answer(input psc_pkg::psc_mode_t m);
    case (m)
      psc_pkg::PSC_LOCAL:    mode_answer = psc_pkg::MODE_LOCAL_ANS;
      psc_pkg::PSC_REMOTE:   mode_answer = psc_pkg::MODE_REMOTE_ANS;
      psc_pkg::PSC_SERIAL_A: mode_answer = psc_pkg::MODE_SERIAL_A_ANS;
      default:               mode_answer = psc_pkg::MODE_SERIAL_B_ANS;
    endcase
  endfunction : mode_answer

  // -----------------------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------------------
  psc_pkg::psc_run_t run_reg;
  psc_pkg::psc_run_t run_next;
  logic              buzz_reg;
  logic              buzz_next;
  logic              alarm_reg;
  logic              alarm_next;
  logic              accel_reg;
  logic              accel_next;
  logic              decel_reg;
  logic              decel_next;
  logic              ans_valid_reg;
  logic              ans_valid_next;
  logic [15:0]       ans_code_reg;
  logic [15:0]       ans_code_next;
  logic [15:0]       ans_sub_reg;
  logic [15:0]       ans_sub_next;
  logic              ans_port_reg;
  logic              ans_port_next;
  logic              mode_cmd;
  logic              op_cmd;
  logic              port_ok;
  logic              do_start;
  logic              do_stop;
  logic              do_reset;

  // a serial operation command is honoured only from the port owning the mode
  always_comb begin
    mode_cmd = cmd_valid && (cmd_code == psc_pkg::MODE_QUERY_CMD
                          || cmd_code == psc_pkg::ONLINE_REQUEST_CMD
                          || cmd_code == psc_pkg::OFFLINE_REQUEST_CMD);
    op_cmd   = cmd_valid && (cmd_code == psc_pkg::START_CMD
                          || cmd_code == psc_pkg::STOP_CMD
                          || cmd_code == psc_pkg::RESET_CMD);
    port_ok  = (mode == psc_pkg::PSC_SERIAL_A && cmd_port == psc_pkg::PORT_A)
            || (mode == psc_pkg::PSC_SERIAL_B && cmd_port == psc_pkg::PORT_B);
    // panel buttons act only in local mode, so they never race serial answers
    do_start = (op_cmd && port_ok && cmd_code == psc_pkg::START_CMD)
            || (mode == psc_pkg::PSC_LOCAL && btn_start);
    do_stop  = (op_cmd && port_ok && cmd_code == psc_pkg::STOP_CMD)
            || (mode == psc_pkg::PSC_LOCAL && btn_stop);
    do_reset = (op_cmd && port_ok && cmd_code == psc_pkg::RESET_CMD)
            || (mode == psc_pkg::PSC_LOCAL && btn_reset);
  end

  // -----------------------------------------------------------------------------
  // run, alarm and answer next-state
  // -----------------------------------------------------------------------------
  always_comb begin
    run_next       = run_reg;
    buzz_next      = buzz_reg;
    alarm_next     = alarm_reg;
    ans_valid_next = 1'b0;
    ans_code_next  = ans_code_reg;
    ans_sub_next   = ans_sub_reg;
    ans_port_next  = ans_port_reg;

    // run progression from the motor's own status
    if (run_reg == psc_pkg::PSC_ACCEL && speed_reached) begin
      run_next = psc_pkg::PSC_NORMAL;
    end else if (run_reg == psc_pkg::PSC_DECEL && speed_zero) begin
      run_next = psc_pkg::PSC_STOPPED;
    end

    // a new fault latches the alarm and sounds the buzzer
    if (fault_present && !alarm_reg) begin
      alarm_next = 1'b1;
      buzz_next  = 1'b1;
      run_next   = psc_pkg::PSC_DECEL;
    end

    if (mode_cmd) begin
      ans_valid_next = 1'b1;
      ans_port_next  = cmd_port;
      ans_sub_next   = psc_pkg::NO_SUB;
      // answer reflects the mode as it stands after the request, unless remote_sel changes in the same cycle
      if (cmd_code == psc_pkg::MODE_QUERY_CMD) begin
        ans_code_next = mode_answer(mode);
      end else if (cmd_code == psc_pkg::ONLINE_REQUEST_CMD && mode == psc_pkg::PSC_REMOTE) begin
        ans_code_next = (cmd_port == psc_pkg::PORT_B) ? psc_pkg::MODE_SERIAL_B_ANS
                                                      : psc_pkg::MODE_SERIAL_A_ANS;
      end else if (cmd_code == psc_pkg::OFFLINE_REQUEST_CMD
                   && (mode == psc_pkg::PSC_SERIAL_A || mode == psc_pkg::PSC_SERIAL_B)) begin
        ans_code_next = psc_pkg::MODE_REMOTE_ANS;
      end else begin
        ans_code_next = mode_answer(mode);
      end
    end else if (op_cmd && !port_ok) begin
      ans_valid_next = 1'b1;
      ans_port_next  = cmd_port;
      ans_sub_next   = psc_pkg::NO_SUB;
      ans_code_next  = psc_pkg::OPERATION_INVALID_ANS;
    end else if (op_cmd) begin
      ans_valid_next = 1'b1;
      ans_port_next  = cmd_port;
      ans_sub_next   = psc_pkg::NO_SUB;
      ans_code_next  = psc_pkg::OPERATION_INVALID_ANS;
    end
    // cmd_valid with any other code falls through untouched

    // panel presses carry no answer: only a serial command (port_ok) may touch it
    if (do_start) begin
      // a fault arriving in the same cycle wins over the start
      if ((run_reg == psc_pkg::PSC_STOPPED || run_reg == psc_pkg::PSC_DECEL) && !alarm_reg
          && !fault_present) begin
        run_next = psc_pkg::PSC_ACCEL;
        if (port_ok) begin
          ans_code_next = psc_pkg::ACCEL_STARTED_ANS;
        end
      end
    end else if (do_stop) begin
      if (run_reg == psc_pkg::PSC_ACCEL || run_reg == psc_pkg::PSC_NORMAL) begin
        run_next = psc_pkg::PSC_DECEL;
        if (port_ok) begin
          ans_code_next = psc_pkg::DECEL_STARTED_ANS;
        end
      end
    end else if (do_reset && alarm_reg) begin
      // reset without a latched alarm keeps the invalid answer
      if (buzz_reg) begin
        buzz_next = 1'b0;
        if (port_ok) begin
          ans_code_next = psc_pkg::BUZZER_OFF_ANS;
        end
      end else if (!fault_present) begin
        alarm_next = 1'b0;
        if (port_ok) begin
          ans_code_next = psc_pkg::FAILURE_CLEARED_ANS;
        end
      end else begin
        // cause still there: alarm stays latched, buzzer comes back
        buzz_next = 1'b1;
        if (port_ok) begin
          ans_code_next = psc_pkg::FAILURE_PERSISTS_ANS;
          ans_sub_next  = fault_code;
        end
      end
    end

    accel_next = (run_next == psc_pkg::PSC_ACCEL);
    decel_next = (run_next == psc_pkg::PSC_DECEL);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_reg       <= psc_pkg::PSC_STOPPED;
      buzz_reg      <= 1'b0;
      alarm_reg     <= 1'b0;
      accel_reg     <= 1'b0;
      decel_reg     <= 1'b0;
      ans_valid_reg <= 1'b0;
      ans_code_reg  <= 16'h0000;
      ans_sub_reg   <= 16'h0000;
      ans_port_reg  <= 1'b0;
    end else if (ce) begin
      run_reg       <= run_next;
      buzz_reg      <= buzz_next;
      alarm_reg     <= alarm_next;
      accel_reg     <= accel_next;
      decel_reg     <= decel_next;
      ans_valid_reg <= ans_valid_next;
      ans_code_reg  <= ans_code_next;
      ans_sub_reg   <= ans_sub_next;
      ans_port_reg  <= ans_port_next;
    end
  end

  // -----------------------------------------------------------------------------
  // outputs, all registered
  // -----------------------------------------------------------------------------
  always_comb begin
    ans_valid     = ans_valid_reg;
    ans_code      = ans_code_reg;
    ans_sub       = ans_sub_reg;
    ans_port      = ans_port_reg;
    accel_cmd     = accel_reg;
    decel_cmd     = decel_reg;
    buzzer_on     = buzz_reg;
    alarm_latched = alarm_reg;
    mode_out      = mode;
  end

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  one_answer_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && (mode_cmd || op_cmd)) |=> ans_valid_reg)
    else $error("command without answer");

  unknown_silent_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && !mode_cmd && !op_cmd) |=> !ans_valid_reg)
    else $error("answer without command");

  wrong_port_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && op_cmd && !port_ok && mode != psc_pkg::PSC_LOCAL && !fault_present
     && !speed_reached && !speed_zero)
    |=> ans_code_reg == psc_pkg::OPERATION_INVALID_ANS && $stable(run_reg))
    else $error("wrong-port command not refused");

  start_accel_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && op_cmd && port_ok && cmd_code == psc_pkg::START_CMD && run_reg == psc_pkg::PSC_STOPPED
     && !alarm_reg && !fault_present)
    |=> accel_cmd && ans_code_reg == psc_pkg::ACCEL_STARTED_ANS)
    else $error("start did not accelerate");

  start_busy_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && op_cmd && port_ok && cmd_code == psc_pkg::START_CMD && run_reg == psc_pkg::PSC_ACCEL)
    |=> ans_code_reg == psc_pkg::OPERATION_INVALID_ANS)
    else $error("start during acceleration accepted");

  stop_decel_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && op_cmd && port_ok && cmd_code == psc_pkg::STOP_CMD && run_reg == psc_pkg::PSC_NORMAL)
    |=> decel_cmd && ans_code_reg == psc_pkg::DECEL_STARTED_ANS)
    else $error("stop did not decelerate");

  buzzer_reset_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && port_ok && do_reset && alarm_reg && buzz_reg)
    |=> !buzz_reg && alarm_reg && ans_code_reg == psc_pkg::BUZZER_OFF_ANS)
    else $error("buzzer reset wrong");

  alarm_clear_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && do_reset && alarm_reg && !buzz_reg && !fault_present)
    |=> !alarm_reg)
    else $error("alarm not cleared");

  persist_code_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && port_ok && do_reset && alarm_reg && !buzz_reg && fault_present)
    |=> buzz_reg && ans_sub_reg == $past(fault_code)
        && ans_code_reg == psc_pkg::FAILURE_PERSISTS_ANS)
    else $error("persisting failure answer wrong");

  normal_reset_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && do_reset && !alarm_reg && !fault_present && !speed_reached && !speed_zero)
    |=> $stable(run_reg))
    else $error("reset disturbed normal run");

  query_mode_c : cover property (@(posedge mclk) disable iff (rst)
    ce && cmd_valid && cmd_code == psc_pkg::MODE_QUERY_CMD);
  online_c : cover property (@(posedge mclk) disable iff (rst)
    mode == psc_pkg::PSC_REMOTE ##1 mode == psc_pkg::PSC_SERIAL_B);
  start_c : cover property (@(posedge mclk) disable iff (rst)
    ans_valid_reg && ans_code_reg == psc_pkg::ACCEL_STARTED_ANS);
  persist_c : cover property (@(posedge mclk) disable iff (rst)
    ans_valid_reg && ans_code_reg == psc_pkg::FAILURE_PERSISTS_ANS);

endmodule : psc_cmd_core

// File: common/psc_pkg.sv
// shared constants and types for the pump supply command interpreter
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package psc_pkg;

  // -----------------------------------------------------------------------------
  // two-character codes, first char in [15:8]
  // -----------------------------------------------------------------------------
  localparam logic [15:0] MODE_QUERY_CMD        = 16'h4C53;
  localparam logic [15:0] ONLINE_REQUEST_CMD    = 16'h4C4E;
  localparam logic [15:0] OFFLINE_REQUEST_CMD   = 16'h4C46;
  localparam logic [15:0] START_CMD             = 16'h5254;
  localparam logic [15:0] STOP_CMD              = 16'h5250;
  localparam logic [15:0] RESET_CMD             = 16'h5252;
  localparam logic [15:0] MODE_LOCAL_ANS        = 16'h4C4C;
  localparam logic [15:0] MODE_REMOTE_ANS       = 16'h4C52;
  localparam logic [15:0] MODE_SERIAL_A_ANS     = 16'h4C43;
  localparam logic [15:0] MODE_SERIAL_B_ANS     = 16'h4C44;
  localparam logic [15:0] ACCEL_STARTED_ANS     = 16'h5241;
  localparam logic [15:0] DECEL_STARTED_ANS     = 16'h5242;
  localparam logic [15:0] BUZZER_OFF_ANS        = 16'h525A;
  localparam logic [15:0] FAILURE_CLEARED_ANS   = 16'h5243;
  localparam logic [15:0] FAILURE_PERSISTS_ANS  = 16'h5246;
  localparam logic [15:0] OPERATION_INVALID_ANS = 16'h5256;
  localparam logic [15:0] NO_SUB                = 16'h0000;

  // port selector values
  localparam logic        PORT_A = 1'b0;
  localparam logic        PORT_B = 1'b1;

  // -----------------------------------------------------------------------------
  // types
  // -----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSC_LOCAL    = 2'b00,
    PSC_REMOTE   = 2'b01,
    PSC_SERIAL_A = 2'b11,
    PSC_SERIAL_B = 2'b10
  } psc_mode_t;

  typedef enum logic [1:0] {
    PSC_STOPPED = 2'b00,
    PSC_ACCEL   = 2'b01,
    PSC_NORMAL  = 2'b11,
    PSC_DECEL   = 2'b10
  } psc_run_t;

endpackage : psc_pkg

// File: rtl/psc_mode_fsm.sv
// operation mode machine: local, remote and the two serial modes
module psc_mode_fsm (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              remote_sel,
  input  wire logic              cmd_valid,
  input  wire logic [15:0]       cmd_code,
  input  wire logic              cmd_port,
  output psc_pkg::psc_mode_t     mode
);

  psc_pkg::psc_mode_t mode_reg;
  psc_pkg::psc_mode_t mode_next;
  logic               sel_reg;
  logic               sel_next;

  assign mode = mode_reg;

  always_comb begin
    mode_next = mode_reg;
    sel_next  = remote_sel;
    if (remote_sel != sel_reg) begin
      // selector wins over a command in the same cycle
      mode_next = remote_sel ? psc_pkg::PSC_REMOTE : psc_pkg::PSC_LOCAL;
    end else if (cmd_valid && cmd_code == psc_pkg::ONLINE_REQUEST_CMD) begin
      if (mode_reg == psc_pkg::PSC_REMOTE) begin
        mode_next = (cmd_port == psc_pkg::PORT_B) ? psc_pkg::PSC_SERIAL_B
                                                  : psc_pkg::PSC_SERIAL_A;
      end
    end else if (cmd_valid && cmd_code == psc_pkg::OFFLINE_REQUEST_CMD) begin
      if (mode_reg == psc_pkg::PSC_SERIAL_A || mode_reg == psc_pkg::PSC_SERIAL_B) begin
        mode_next = psc_pkg::PSC_REMOTE;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg <= psc_pkg::PSC_LOCAL;
      sel_reg  <= 1'b0;
    end else if (ce) begin
      mode_reg <= mode_next;
      sel_reg  <= sel_next;
    end
  end

  offline_remote_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && sel_reg == remote_sel && cmd_valid && cmd_code == psc_pkg::OFFLINE_REQUEST_CMD
     && (mode_reg == psc_pkg::PSC_SERIAL_A || mode_reg == psc_pkg::PSC_SERIAL_B))
    |=> mode_reg == psc_pkg::PSC_REMOTE)
    else $error("offline did not return to remote");

  online_port_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && sel_reg == remote_sel && cmd_valid && cmd_code == psc_pkg::ONLINE_REQUEST_CMD
     && mode_reg == psc_pkg::PSC_REMOTE && cmd_port == psc_pkg::PORT_B)
    |=> mode_reg == psc_pkg::PSC_SERIAL_B)
    else $error("online did not select requesting port");

  selector_mode_a : assert property (@(posedge mclk) disable iff (rst)
    (ce && remote_sel != sel_reg) |=> mode_reg == (sel_reg ? psc_pkg::PSC_REMOTE
                                                           : psc_pkg::PSC_LOCAL))
    else $error("selector change not followed");

endmodule : psc_mode_fsm

// File: verification/psc_host_model.sv
// host computer model: issues one command and waits for its answer
module psc_host_model (
  input  wire logic        mclk,
  input  wire logic        ans_valid,
  output logic             cmd_valid,
  output logic [15:0]      cmd_code,
  output logic             cmd_port
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 16'h0000;
    cmd_port  = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // command transfer
  // ---------------------------------------------------------------------------
  // gap idles the host for extra cycles so both prompt and slow hosts are seen
  task automatic send(input logic [15:0] code, input logic port, input int gap,
                      output int lat);
    repeat (gap + 1) @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_port  = port;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    // released lines carry the inverse so a stale value cannot pass for data
    cmd_code  = ~code;
    cmd_port  = ~port;
    lat = 0;
    // no further command until the answer is in or the window has gone
    for (int i = 1; i <= 3 && lat == 0; i++) begin
      if (ans_valid === 1'b1) begin
        lat = i;
      end else begin
        @(posedge mclk);
        #1;
      end
    end
  endtask : send
endmodule : psc_host_model

// File: verification/psc_cmd_core_tb.sv
// self-checking bench for the command interpreter against a reference model
module psc_cmd_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        remote_sel = 1'b0;
  logic        ce = 1'b1;
  logic        cmd_valid, cmd_port, ans_valid, ans_port;
  logic [15:0] cmd_code, ans_code, ans_sub, ex_code, ex_sub;
  logic        btn_start = 1'b0, btn_stop = 1'b0, btn_reset = 1'b0;
  logic        fault_present = 1'b0, speed_reached = 1'b0, speed_zero = 1'b0;
  logic [15:0] fault_code = 16'h0000;
  logic        accel_cmd, decel_cmd, buzzer_on, alarm_latched;
  logic [1:0]  mode_out;
  logic [31:0] seed = 32'h00000052;
  int          num_errors = 0;
  int          n_compared = 0;
  int          m_mode = 0, m_run = 0, m_buz = 0, m_alarm = 0, lat;

  always #5 mclk = ~mclk;

  psc_cmd_core psc_cmd_core_i (.mclk(mclk), .rst(rst), .ce(ce), .remote_sel(remote_sel),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_port(cmd_port), .btn_start(btn_start),
    .btn_stop(btn_stop), .btn_reset(btn_reset), .fault_present(fault_present),
    .fault_code(fault_code), .speed_reached(speed_reached), .speed_zero(speed_zero),
    .ans_valid(ans_valid), .ans_code(ans_code), .ans_sub(ans_sub), .ans_port(ans_port),
    .accel_cmd(accel_cmd), .decel_cmd(decel_cmd), .buzzer_on(buzzer_on),
    .alarm_latched(alarm_latched), .mode_out(mode_out));

  psc_host_model psc_host_model_i (.mclk(mclk), .ans_valid(ans_valid),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_port(cmd_port));

  // ---------------------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs

  function automatic logic [15:0] mode_ans(input int m);
    case (m)
      0: return psc_pkg::MODE_LOCAL_ANS;
      1: return psc_pkg::MODE_REMOTE_ANS;
      2: return psc_pkg::MODE_SERIAL_A_ANS;
      default: return psc_pkg::MODE_SERIAL_B_ANS;
    endcase
  endfunction : mode_ans

  // start, stop and reset as the reference sees them; gives the answer due
  function automatic logic [15:0] ref_op(input logic [15:0] code);
    ex_sub = psc_pkg::NO_SUB;
    if (code == psc_pkg::START_CMD) begin
      if ((m_run == 0 || m_run == 3) && m_alarm == 0) begin
        m_run = 1;
        return psc_pkg::ACCEL_STARTED_ANS;
      end
    end else if (code == psc_pkg::STOP_CMD) begin
      if (m_run == 1 || m_run == 2) begin
        m_run = 3;
        return psc_pkg::DECEL_STARTED_ANS;
      end
    end else if (m_alarm != 0) begin
      if (m_buz != 0) begin
        m_buz = 0;
        return psc_pkg::BUZZER_OFF_ANS;
      end
      if (fault_present) begin
        m_buz = 1;
        ex_sub = fault_code;
        return psc_pkg::FAILURE_PERSISTS_ANS;
      end
      m_alarm = 0;
      return psc_pkg::FAILURE_CLEARED_ANS;
    end
    return psc_pkg::OPERATION_INVALID_ANS;
  endfunction : ref_op

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk_levels();
    psc_pkg::psc_mode_t enc [4];
    enc = '{psc_pkg::PSC_LOCAL, psc_pkg::PSC_REMOTE, psc_pkg::PSC_SERIAL_A,
            psc_pkg::PSC_SERIAL_B};
    chk("mode_out", 16'(enc[m_mode]), 16'(mode_out));
    chk("accel_cmd", 16'(m_run == 1), 16'(accel_cmd));
    chk("decel_cmd", 16'(m_run == 3), 16'(decel_cmd));
    chk("buzzer_on", 16'(m_buz), 16'(buzzer_on));
    chk("alarm_latched", 16'(m_alarm), 16'(alarm_latched));
  endtask : chk_levels

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
    chk_levels();
  endtask : pulse

  task automatic cmd(input logic [15:0] code, input logic port);
    logic own;
    int   ex_lat;
    own = (m_mode == 2 && port == 1'b0) || (m_mode == 3 && port == 1'b1);
    ex_lat = 1;
    ex_sub = psc_pkg::NO_SUB;
    case (code)
      psc_pkg::MODE_QUERY_CMD: ex_code = mode_ans(m_mode);
      psc_pkg::ONLINE_REQUEST_CMD: begin
        if (m_mode == 1) m_mode = port ? 3 : 2;
        ex_code = mode_ans(m_mode);
      end
      psc_pkg::OFFLINE_REQUEST_CMD: begin
        if (m_mode >= 2) m_mode = 1;
        ex_code = mode_ans(m_mode);
      end
      psc_pkg::START_CMD, psc_pkg::STOP_CMD, psc_pkg::RESET_CMD:
        ex_code = own ? ref_op(code) : psc_pkg::OPERATION_INVALID_ANS;
      default: ex_lat = 0;
    endcase
    // a frozen core takes no command, so none is answered
    if (ce !== 1'b1) begin
      ex_lat = 0;
    end
    seed = xs(seed);
    psc_host_model_i.send(code, port, int'(seed[1:0]), lat);
    chk("latency", 16'(ex_lat), 16'(lat));
    if (ex_lat == 1) begin
      chk("ans_code", ex_code, ans_code);
      chk("ans_sub", ex_sub, ans_sub);
      chk("ans_port", 16'(port), 16'(ans_port));
    end
    tick(1);
    chk_levels();
  endtask : cmd

  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    tick(4);
    rst = 1'b0;
    tick(1);
    chk_levels();
    cmd(psc_pkg::MODE_QUERY_CMD, 1'b0);
    cmd(psc_pkg::ONLINE_REQUEST_CMD, 1'b0);
    cmd(psc_pkg::START_CMD, 1'b0);
    void'(ref_op(psc_pkg::START_CMD));
    pulse(btn_start);
    void'(ref_op(psc_pkg::STOP_CMD));
    pulse(btn_stop);
    m_run = 0;
    pulse(speed_zero);
    remote_sel = 1'b1;
    m_mode = 1;
    tick(2);
    cmd(psc_pkg::OFFLINE_REQUEST_CMD, 1'b0);
    cmd(psc_pkg::ONLINE_REQUEST_CMD, 1'b1);
    cmd(psc_pkg::ONLINE_REQUEST_CMD, 1'b0);
    cmd(psc_pkg::START_CMD, 1'b0);
    pulse(btn_start);                        // panel is ignored outside local
    cmd(psc_pkg::START_CMD, 1'b1);
    cmd(psc_pkg::START_CMD, 1'b1);
    m_run = 2;
    pulse(speed_reached);
    cmd(psc_pkg::RESET_CMD, 1'b1);
    cmd(psc_pkg::STOP_CMD, 1'b1);
    cmd(psc_pkg::STOP_CMD, 1'b1);
    cmd(psc_pkg::START_CMD, 1'b1);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      cmd({8'h58, seed[7:0]}, seed[8]);
    end
    seed = xs(seed);
    fault_code = seed[15:0] | 16'h0101;
    fault_present = 1'b1;
    m_alarm = 1;
    m_buz = 1;
    m_run = 3;
    tick(2);
    cmd(psc_pkg::START_CMD, 1'b1);
    cmd(psc_pkg::RESET_CMD, 1'b1);
    cmd(psc_pkg::RESET_CMD, 1'b1);
    cmd(psc_pkg::RESET_CMD, 1'b1);
    fault_present = 1'b0;
    cmd(psc_pkg::RESET_CMD, 1'b1);
    m_run = 0;
    pulse(speed_zero);
    cmd(psc_pkg::OFFLINE_REQUEST_CMD, 1'b1);
    cmd(psc_pkg::ONLINE_REQUEST_CMD, 1'b0);
    cmd(psc_pkg::MODE_QUERY_CMD, 1'b1);
    cmd(psc_pkg::OFFLINE_REQUEST_CMD, 1'b0);
    cmd(psc_pkg::ONLINE_REQUEST_CMD, 1'b0);
    remote_sel = 1'b0;
    m_mode = 0;
    tick(2);
    cmd(psc_pkg::MODE_QUERY_CMD, 1'b0);
    ce = 1'b0;
    cmd(psc_pkg::MODE_QUERY_CMD, 1'b0);      // frozen core stays silent
    pulse(btn_start);                        // frozen core ignores the panel
    ce = 1'b1;
    void'(ref_op(psc_pkg::START_CMD));
    pulse(btn_start);
    end_of_test();
  end
endmodule : psc_cmd_core_tb
